// ==== pkg/swb_pkg.sv ====
// Package of constants and carrier types for the subtract-with-borrow datapath slice.
//------------------------------------------------------------------------------
// Contract
//------------------------------------------------------------------------------
// Contract
// - Borrow subtract gives file value minus accumulator minus inverted carry.
// - Instruction word top six bits 010110, then destination, bank, 8-bit register.
// - Destination 0 writes accumulator, 1 writes the addressed file register.
// - Bank 0 takes the access bank, 1 uses the bank select register.
// - Bank 0 with extended set enabled uses indexed offset when register field <= 95.
// - Two's complement subtract updates negative, overflow, carry, digit-carry, zero.
// - Underflow such as 02h minus 03h gives FFh, carry 0, zero 0, negative 1.
// - Exactly zero result sets zero and carry, clears negative.
// - Positive nonzero result without borrow sets carry, clears zero and negative.
// - One instruction cycle of four phases: decode, read, process, write.
package swb_pkg;

    //--------------------------------------------------------------------------
    // Encodings
    //--------------------------------------------------------------------------
    localparam logic [5:0] OPC_SUB_ACC_FILE_BORROW = 6'h16;
    localparam logic [5:0] OPC_SUB_ACC_FILE        = 6'h17;
    localparam logic [7:0] OPC_SUB_ACC_LITERAL     = 8'h08;
    localparam int         OPC_HI                  = 15;
    localparam int         OPC_LO                  = 10;
    localparam int         DEST_BIT                = 9;
    localparam int         BANK_BIT                = 8;
    localparam logic [7:0] INDEXED_LIMIT           = 8'h5f;
    localparam logic [7:0] ACCESS_SPLIT            = 8'h60;
    localparam logic [3:0] ACCESS_HIGH_BANK        = 4'hf;

    //--------------------------------------------------------------------------
    // Flag positions and reset values
    //--------------------------------------------------------------------------
    localparam int         FLAG_C   = 0;
    localparam int         FLAG_DC  = 1;
    localparam int         FLAG_Z   = 2;
    localparam int         FLAG_OV  = 3;
    localparam int         FLAG_N   = 4;
    localparam logic [4:0] FLAGS_RST = 5'h00;
    localparam logic [7:0] ACC_RST   = 8'h00;

    //--------------------------------------------------------------------------
    // Phase sequencer
    //--------------------------------------------------------------------------
    typedef enum logic [1:0] {
        PH_DECODE  = 2'b00,
        PH_READ    = 2'b01,
        PH_PROCESS = 2'b10,
        PH_WRITE   = 2'b11
    } swb_phase_e;

    typedef enum logic [1:0] {
        OP_NONE    = 2'b00,
        OP_SUBB    = 2'b01,
        OP_SUB     = 2'b10,
        OP_SUB_LIT = 2'b11
    } swb_op_e;

    // Data memory access toward the file register array.
    typedef struct packed {
        logic        en;
        logic        idx;
        logic [11:0] addr;
        logic [7:0]  data;
    } swb_mem_s;

endpackage

// ==== design/swb_alu.sv ====
// Subtract-with-borrow datapath slice with four-phase instruction sequencing.
`timescale 1ns/10ps
`default_nettype none
module swb_alu #(
    parameter int DATA_W = 8
) (
    // Clock and reset
    input  wire logic             i_clk,
    input  wire logic             i_rst,
    // Instruction fetch side
    input  wire logic             i_instr_valid,
    input  wire logic [15:0]      i_instr,
    input  wire logic             i_ext_en,
    input  wire logic [3:0]       i_bank_select_reg,
    // File register read data
    input  wire logic [7:0]       i_rd_data,
    // File register access
    output var  swb_pkg::swb_mem_s o_rd,
    output var  swb_pkg::swb_mem_s o_wr,
    // Core state
    output logic [7:0]            o_acc,
    output logic [4:0]            o_flags,
    output logic [1:0]            o_phase,
    output logic                  o_busy,
    output logic                  o_done
);

    //--------------------------------------------------------------------------
    // Parameter check
    //--------------------------------------------------------------------------
    // The flag logic and the operand registers are built for one byte only.
    if (DATA_W != 8) begin : g_width_check
        $error("swb_alu serves an 8-bit data path only");
    end

    //--------------------------------------------------------------------------
    // State
    //--------------------------------------------------------------------------
    swb_pkg::swb_phase_e phase_reg;
    swb_pkg::swb_op_e    op_reg;
    logic [15:0]         instr_reg;
    logic [11:0]         addr_reg;
    logic                idx_reg;
    logic [7:0]          opnd_reg;
    logic [7:0]          res_reg;
    logic [4:0]          flags_reg;
    logic [7:0]          acc_reg;
    swb_pkg::swb_mem_s   rd_reg;
    swb_pkg::swb_mem_s   wr_reg;
    logic                done_reg;
    logic                busy_reg;

    //--------------------------------------------------------------------------
    // Decode
    //--------------------------------------------------------------------------
    swb_pkg::swb_op_e dec_op;
    logic [7:0]       dec_f;
    logic             dec_bank;
    logic             dec_idx;
    logic [11:0]      dec_addr;

    always_comb begin
        dec_f    = i_instr[7:0];
        dec_bank = i_instr[swb_pkg::BANK_BIT];
        dec_op   = swb_pkg::OP_NONE;
        if (i_instr[swb_pkg::OPC_HI:swb_pkg::OPC_LO] == swb_pkg::OPC_SUB_ACC_FILE_BORROW) begin
            dec_op = swb_pkg::OP_SUBB;
        end else if (i_instr[swb_pkg::OPC_HI:swb_pkg::OPC_LO] == swb_pkg::OPC_SUB_ACC_FILE) begin
            dec_op = swb_pkg::OP_SUB;
        end else if (i_instr[15:8] == swb_pkg::OPC_SUB_ACC_LITERAL) begin
            dec_op = swb_pkg::OP_SUB_LIT;
        end
        // Indexed mode is flagged; the index base is added outside this slice.
        dec_idx = !dec_bank && i_ext_en && (dec_f <= swb_pkg::INDEXED_LIMIT);
        if (dec_bank) begin
            dec_addr = {i_bank_select_reg, dec_f};
        end else if (dec_f < swb_pkg::ACCESS_SPLIT) begin
            dec_addr = {4'h0, dec_f};
        end else begin
            dec_addr = {swb_pkg::ACCESS_HIGH_BANK, dec_f};
        end
    end

    //--------------------------------------------------------------------------
    // Subtractor
    //--------------------------------------------------------------------------
    logic [7:0] minuend;
    logic [7:0] subtrahend;
    logic       borrow_in;
    logic [8:0] diff;
    logic [4:0] nib;
    logic [4:0] flags_next;

    always_comb begin
        if (op_reg == swb_pkg::OP_SUB_LIT) begin
            minuend = instr_reg[7:0];
        end else begin
            minuend = opnd_reg;
        end
        subtrahend = acc_reg;
        // Carry acts as not-borrow only for the borrow form.
        borrow_in  = (op_reg == swb_pkg::OP_SUBB) ? !flags_reg[swb_pkg::FLAG_C] : 1'b0;
        diff = {1'b0, minuend} - {1'b0, subtrahend} - {8'h00, borrow_in};
        nib  = {1'b0, minuend[3:0]} - {1'b0, subtrahend[3:0]} - {4'h0, borrow_in};
        flags_next = 5'h00;
        flags_next[swb_pkg::FLAG_C]  = !diff[8];
        flags_next[swb_pkg::FLAG_DC] = !nib[4];
        flags_next[swb_pkg::FLAG_Z]  = (diff[7:0] == 8'h00);
        flags_next[swb_pkg::FLAG_N]  = diff[7];
        flags_next[swb_pkg::FLAG_OV] = (minuend[7] != subtrahend[7])
                                     && (diff[7] != minuend[7]);
    end

    //--------------------------------------------------------------------------
    // Phase sequencer
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            phase_reg <= swb_pkg::PH_DECODE;
            busy_reg  <= 1'b0;
        end else begin
            case (phase_reg)
                swb_pkg::PH_DECODE: begin
                    if (i_instr_valid && dec_op != swb_pkg::OP_NONE) begin
                        phase_reg <= swb_pkg::PH_READ;
                        busy_reg  <= 1'b1;
                    end
                end
                swb_pkg::PH_READ: begin
                    phase_reg <= swb_pkg::PH_PROCESS;
                end
                swb_pkg::PH_PROCESS: begin
                    phase_reg <= swb_pkg::PH_WRITE;
                end
                swb_pkg::PH_WRITE: begin
                    phase_reg <= swb_pkg::PH_DECODE;
                    busy_reg  <= 1'b0;
                end
                default: begin
                    phase_reg <= swb_pkg::PH_DECODE;
                    busy_reg  <= 1'b0;
                end
            endcase
        end
    end

    //--------------------------------------------------------------------------
    // Instruction capture and operand read
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            op_reg    <= swb_pkg::OP_NONE;
            instr_reg <= 16'h0000;
            addr_reg  <= 12'h000;
            idx_reg   <= 1'b0;
            rd_reg    <= '0;
            opnd_reg  <= 8'h00;
        end else begin
            rd_reg.en <= 1'b0;
            if (phase_reg == swb_pkg::PH_DECODE && i_instr_valid
                    && dec_op != swb_pkg::OP_NONE) begin
                op_reg      <= dec_op;
                instr_reg   <= i_instr;
                addr_reg    <= dec_addr;
                idx_reg     <= dec_idx;
                rd_reg.en   <= (dec_op != swb_pkg::OP_SUB_LIT);
                rd_reg.idx  <= dec_idx;
                rd_reg.addr <= dec_addr;
            end
            if (phase_reg == swb_pkg::PH_READ) begin
                opnd_reg <= i_rd_data;
            end
        end
    end

    //--------------------------------------------------------------------------
    // Process and write-back
    //--------------------------------------------------------------------------
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            res_reg   <= 8'h00;
            flags_reg <= swb_pkg::FLAGS_RST;
            acc_reg   <= swb_pkg::ACC_RST;
            wr_reg    <= '0;
            done_reg  <= 1'b0;
        end else begin
            wr_reg.en <= 1'b0;
            done_reg  <= 1'b0;
            if (phase_reg == swb_pkg::PH_PROCESS) begin
                res_reg   <= diff[7:0];
                flags_reg <= flags_next;
            end
            if (phase_reg == swb_pkg::PH_WRITE) begin
                done_reg <= 1'b1;
                if (op_reg == swb_pkg::OP_SUB_LIT || !instr_reg[swb_pkg::DEST_BIT]) begin
                    acc_reg <= res_reg;
                end else begin
                    wr_reg.en   <= 1'b1;
                    wr_reg.idx  <= idx_reg;
                    wr_reg.addr <= addr_reg;
                    wr_reg.data <= res_reg;
                end
            end
        end
    end

    //--------------------------------------------------------------------------
    // Outputs
    //--------------------------------------------------------------------------
    assign o_rd    = rd_reg;
    assign o_wr    = wr_reg;
    assign o_acc   = acc_reg;
    assign o_flags = flags_reg;
    assign o_phase = phase_reg;
    // Busy is kept in its own flip-flop so the output carries no decode logic.
    assign o_busy  = busy_reg;
    assign o_done  = done_reg;

endmodule
`default_nettype wire

// ==== verif/swb_alu_checker.sv ====
// Assertion checker for the subtract-with-borrow datapath slice.
`timescale 1ns/10ps
`default_nettype none
module swb_alu_checker (
    input wire logic              i_clk,
    input wire logic              i_rst,
    input wire logic              i_instr_valid,
    input wire logic [15:0]       i_instr,
    input wire logic              i_ext_en,
    input wire logic [3:0]        i_bank_select_reg,
    input wire logic [7:0]        i_rd_data,
    input wire swb_pkg::swb_mem_s o_rd,
    input wire swb_pkg::swb_mem_s o_wr,
    input wire logic [7:0]        o_acc,
    input wire logic [4:0]        o_flags,
    input wire logic [1:0]        o_phase,
    input wire logic              o_done
);
    logic take_b;
    logic idx_c;
    assign take_b = o_phase == 2'd0 && i_instr_valid && i_instr[15:10] == 6'h16;
    assign idx_c = !i_instr[8] && i_ext_en && i_instr[7:0] <= 8'h5f;
    default clocking cb @(posedge i_clk); endclocking
    default disable iff (i_rst);
    a_take_read: assert property (take_b |=> o_rd.en && o_phase == 2'd1)
        else $error("read not issued");
    a_phase_walk: assert property (o_phase == 2'd1 |=> o_phase == 2'd2 ##1 o_phase == 2'd3 ##1
        o_phase == 2'd0) else $error("phase order broken");
    a_done_write: assert property (o_phase == 2'd3 |=> o_done)
        else $error("done missing");
    a_no_retake: assert property (o_phase != 2'd0 |=> !o_rd.en)
        else $error("taken while busy");
    a_dest_file: assert property (take_b && i_instr[9] |-> ##4 o_wr.en
        && o_wr.addr[7:0] == $past(i_instr[7:0], 4)) else $error("file write wrong");
    a_dest_acc: assert property (take_b && !i_instr[9] |-> ##4 o_done && !o_wr.en)
        else $error("acc destination wrong");
    a_bank_addr: assert property (o_rd.en && $past(i_instr[8]) |->
        o_rd.addr == {$past(i_bank_select_reg), $past(i_instr[7:0])}) else $error("bank wrong");
    a_index_mode: assert property (o_wr.en |-> o_wr.idx == $past(idx_c, 4))
        else $error("indexed flag wrong");
    a_borrow_math: assert property (o_wr.en && $past(take_b, 4) |-> o_wr.data ==
        $past(i_rd_data, 3) - $past(o_acc, 4) - {7'h00, !$past(o_flags[0], 4)}) else $error("bad sum");
    a_zero_neg: assert property (o_wr.en |-> o_flags[2] == (o_wr.data == 8'h00)
        && o_flags[4] == o_wr.data[7]) else $error("zero or negative wrong");
    c_file: cover property (take_b && i_instr[9]);
    c_under: cover property (o_done && o_flags[4] && !o_flags[0]);
    c_index: cover property (o_wr.en && o_wr.idx);
endmodule
bind swb_alu swb_alu_checker chk_u (.i_clk(i_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid),
    .i_instr(i_instr), .i_ext_en(i_ext_en), .i_bank_select_reg(i_bank_select_reg),
    .i_rd_data(i_rd_data), .o_rd(o_rd), .o_wr(o_wr), .o_acc(o_acc), .o_flags(o_flags),
    .o_phase(o_phase), .o_done(o_done));
`default_nettype wire

// ==== verif/swb_alu_tb_top.sv ====
// Self-checking testbench for the subtract-with-borrow datapath slice.
`timescale 1ns/10ps
`default_nettype none
module swb_alu_tb_top;
    logic              i_clk, i_rst, i_instr_valid, i_ext_en, o_busy, o_done, m_c;
    logic [15:0]       i_instr;
    logic [3:0]        i_bank_select_reg;
    logic [7:0]        i_rd_data, o_acc, m_acc;
    logic [4:0]        o_flags;
    logic [1:0]        o_phase;
    logic [26:0]       x;
    swb_pkg::swb_mem_s o_rd, o_wr;
    logic [26:0]       notes[$];
    int                mismatches, num_checks, seed;
    swb_alu dut_u (.i_clk(i_clk), .i_rst(i_rst), .i_instr_valid(i_instr_valid), .i_instr(i_instr),
        .i_ext_en(i_ext_en), .i_bank_select_reg(i_bank_select_reg), .i_rd_data(i_rd_data),
        .o_rd(o_rd), .o_wr(o_wr), .o_acc(o_acc), .o_flags(o_flags), .o_phase(o_phase),
        .o_busy(o_busy), .o_done(o_done));
    initial begin
        i_clk = 1'b0;
        forever #2 i_clk = ~i_clk;
    end
    task automatic give_verdict;
        $display("checks %0d mismatches %0d", num_checks, mismatches);
        if (mismatches == 0 && num_checks > 0) $display("Simulation passed");
        else $display("Simulation failed");
        $finish;
    endtask
    task automatic check(input logic [26:0] got, input logic [26:0] exp);
        num_checks++;
        if (got !== exp) begin
            mismatches++;
            $display("mismatch at %0t got %h expected %h", $time, got, exp);
        end
    endtask
    // Result in the low byte, flags {N,OV,Z,DC,C} above it.
    function automatic logic [12:0] calc(input logic [7:0] m, input logic [7:0] s, input logic b);
        logic [8:0] r;
        logic [4:0] lo;
        r = {1'b0, m} - {1'b0, s} - {8'h00, b};
        lo = {1'b0, m[3:0]} - {1'b0, s[3:0]} - {4'h0, b};
        calc = {r[7], m[7] != s[7] && r[7] != m[7], r[7:0] == 8'h00, ~lo[4], ~r[8], r[7:0]};
    endfunction
    task automatic run(input logic [15:0] w, input logic [7:0] fd);
        logic [12:0] e;
        logic        lit;
        logic [11:0] ad;
        int          n;
        lit = w[15:8] == swb_pkg::OPC_SUB_ACC_LITERAL;
        e = calc(lit ? w[7:0] : fd, m_acc, w[15:10] == swb_pkg::OPC_SUB_ACC_FILE_BORROW && !m_c);
        ad = {w[8] ? i_bank_select_reg : (w[7:0] < 8'h60 ? 4'h0 : 4'hf), w[7:0]};
        notes.push_back({!lit && w[9], ad, e, !w[8] && i_ext_en && w[7:0] <= 8'h5f});
        m_c = e[8];
        if (lit || !w[9]) m_acc = e[7:0];
        i_instr = w;
        i_instr_valid = 1'b1;
        i_rd_data = fd;
        @(posedge i_clk) #1;
        i_instr = 16'h5800 | 16'($random(seed));
        @(posedge i_clk) #1;
        i_rd_data = ~fd;
        @(posedge i_clk) #1;
        i_instr_valid = 1'b0;
        n = 0;
        while (o_done !== 1'b1 && n < 10) begin
            @(posedge i_clk) #1;
            n++;
        end
        if (n == 10) begin
            mismatches++;
            give_verdict();
        end
    endtask
    always @(posedge i_clk) begin
        if (o_done === 1'b1) begin
            x = notes.size() > 0 ? notes.pop_front() : 27'h0;
            check({o_wr.en, x[26] ? {o_wr.addr, o_flags, o_wr.data, o_wr.idx} : {12'h0, o_flags, o_acc, 1'b0}}, {x[26], x[26] ? x[25:0] : {12'h0, x[13:1], 1'b0}});
        end
    end
    initial begin
        logic [31:0] rnd;
        logic [15:0] w;
        seed = 74541;
        {i_rst, i_instr_valid, i_ext_en, i_instr, i_bank_select_reg, i_rd_data} = {2'b10, 29'h0};
        {m_acc, m_c, mismatches, num_checks} = 0;
        repeat (12) @(posedge i_clk);
        #1 i_rst = 1'b0;
        run(16'h0802, 8'h00);
        run(16'h0802, 8'h00);
        run(16'h0803, 8'h00);
        run(16'h0802, 8'h00);
        $display("test literal done");
        i_ext_en = 1'b1;
        run(16'h5a5f, 8'h40);
        run(16'h5a60, 8'h3f);
        i_instr = 16'hffff;
        i_instr_valid = 1'b1;
        @(posedge i_clk) #1;
        check({26'h0, o_busy}, 27'h0);
        i_instr_valid = 1'b0;
        $display("test boundary done");
        for (int k = 0; k < 60; k++) begin
            rnd = $random(seed);
            w = rnd[15:0];
            i_ext_en = rnd[16];
            i_bank_select_reg = rnd[20:17];
            if (k % 3 == 2) w[15:8] = 8'h08;
            else w[15:10] = (k % 3 == 0) ? 6'h16 : 6'h17;
            run(w, rnd[31:24]);
        end
        @(posedge i_clk) #1;
        check({26'h0, notes.size() > 0}, 27'h0);
        $display("test random done");
        give_verdict();
    end
endmodule
`default_nettype wire
